// ==== hw/tpm_pkg.sv ====
// Package with constants and types for the timing pin direction mux.
package tpm_pkg;

   // ----------------------------------------------------------------
   // Widths and register map
   // ----------------------------------------------------------------
   localparam int PIN_COUNT = 10;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] REG_DIRECTION = 4'h0;
   localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h1;
   localparam logic [ADDR_W-1:0] REG_PIN_STATUS = 4'h2;
   localparam logic [PIN_COUNT-1:0] DIRECTION_RESET = 10'h000;

   // ----------------------------------------------------------------
   // Control register field positions
   // ----------------------------------------------------------------
   localparam int CTL_AI_STRETCH = 0;
   localparam int CTL_AO_STRETCH = 1;
   localparam int CTL_PIN7_SELECT = 2;
   localparam int CTL_ANALOG_TRIG = 3;
   localparam int CTL_SCAN_MODE_LO = 4;
   localparam int CTL_SCAN_MODE_HI = 5;
   localparam int CTL_CONV_ONE_CYCLE = 6;
   localparam int CTL_CONV_ACT_HIGH = 7;
   localparam int CTL_UPD_ACT_HIGH = 8;
   localparam int CTL_WIDTH = 9;
   localparam logic [CTL_WIDTH-1:0] CONTROL_RESET = 9'h000;

   // Drive modes of the scan active flag on pin 7.
   localparam logic [1:0] SCAN_HIGH_Z = 2'h0;
   localparam logic [1:0] SCAN_ACT_HIGH = 2'h1;

   // Pin indices.
   localparam int PIN_AI_FIRST = 0;
   localparam int PIN_AI_SECOND = 1;
   localparam int PIN_CONVERT = 2;
   localparam int PIN_G1_SOURCE = 3;
   localparam int PIN_G1_GATE = 4;
   localparam int PIN_UPDATE = 5;
   localparam int PIN_AO_FIRST = 6;
   localparam int PIN_AI_START = 7;
   localparam int PIN_G0_SOURCE = 8;
   localparam int PIN_G0_GATE = 9;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   // Stretcher states, Gray coded along idle -> wait1 -> wait2.
   typedef enum logic [1:0] {
      STR_IDLE = 2'b00,
      STR_WAIT1 = 2'b01,
      STR_WAIT2 = 2'b11
   } tpm_stretch_e;

   typedef struct packed {
      logic upd_act_high;
      logic conv_act_high;
      logic conv_one_cycle;
      logic [1:0] scan_active_drive_mode;
      logic analog_trigger_enable;
      logic pin7_source_select;
      logic ao_trigger_stretch_enable;
      logic ai_trigger_stretch_enable;
   } tpm_control_s;

   // Internal timing signals offered to the pins.
   typedef struct packed {
      logic ai_first_trigger_raw;
      logic ai_first_trigger_edge;
      logic ai_second_trigger_raw;
      logic ai_second_trigger_edge;
      logic ai_start_trigger;
      logic conversion_clock_raw;
      logic g1_source;
      logic g1_gate;
      logic ao_update_strobe;
      logic ao_first_trigger_raw;
      logic ao_first_trigger_edge;
      logic scan_active_flag;
      logic g0_source;
      logic g0_gate;
      logic ai_output_timebase;
      logic ao_output_timebase;
      logic analog_trigger;
   } tpm_timing_s;

endpackage

// ==== hw/tpm_pin_mux.sv ====
// Direction control and output selection for the ten timing pins.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RL1: Input pins pass their synchronised level on to the source selectors.
// RL2: Pin 0 shows raw first AI trigger when AI stretch is off.
// RL3: Pin 0 shows first AI trigger stretched to 1-2 AI timebase periods.
// RL4: Pin 1 shows raw second AI trigger when AI stretch is off.
// RL5: Pin 1 shows second AI trigger stretched to 1-2 AI timebase periods.
// RL6: Pin 2 carries the shaped conversion strobe also sent to convert pin.
// RL7: Pin 3 shows counter 1 source.
// RL8: Pin 4 shows counter 1 gate.
// RL9: Pin 5 shows the AO update strobe.
// RL10: Pin 6 shows raw first AO trigger when AO stretch is off.
// RL11: Pin 6 shows first AO trigger stretched to 1-2 AO timebase periods.
// RL12: Pin 7 select 0 gives AI start trigger, raw or stretched.
// RL13: Pin 7 select 1 gives scan active flag with chosen polarity.
// RL14: Scan active flag in high impedance mode drives pin 7 low.
// RL15: Pin 8 shows counter 0 source.
// RL16: Pin 9 shows counter 0 gate.
// RL17: Conversion and update pins default active low, other outputs high.
// RL18: One direction bit per pin: 0 input undriven, 1 drives output.
// RL19: All ten pins come out of reset as inputs.
// RL20: Enabled analog trigger replaces pin 0 input at the selectors.
// RL21: Outside drivers must release a pin before it is set to output.
module tpm_pin_mux (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic [tpm_pkg::ADDR_W-1:0] I_ADDR,
   input wire logic [tpm_pkg::DATA_W-1:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [tpm_pkg::DATA_W-1:0] O_RDATA,
   input wire tpm_pkg::tpm_timing_s I_TIMING,
   input wire logic [tpm_pkg::PIN_COUNT-1:0] I_TIMING_PIN_IN,
   output logic [tpm_pkg::PIN_COUNT-1:0] O_TIMING_PIN_OUT,
   output logic [tpm_pkg::PIN_COUNT-1:0] O_TIMING_PIN_OE,
   output logic [tpm_pkg::PIN_COUNT-1:0] O_SELECTOR_IN,
   output logic O_SHAPED_CONVERSION_STROBE
);
   import tpm_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [PIN_COUNT-1:0] dir_reg, dir_next;
   tpm_control_s ctl_reg, ctl_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic [PIN_COUNT-1:0] sync1_reg, sync2_reg;
   logic [PIN_COUNT-1:0] sel_reg, sel_next;
   logic [PIN_COUNT-1:0] out_reg, out_next;
   logic conv_reg, conv_next;
   logic conv_prev_reg;
   logic ai_tb_prev_reg, ao_tb_prev_reg;
   tpm_stretch_e str0_reg, str0_next;
   tpm_stretch_e str1_reg, str1_next;
   tpm_stretch_e str6_reg, str6_next;
   tpm_stretch_e str7_reg, str7_next;
   logic ai_tb_rise, ao_tb_rise;
   logic conv_shaped;

   // One step of a trigger stretcher. A new trigger restarts the wait,
   // and two timebase rises must pass before it goes idle, so the
   // stretched pulse lasts between one and two timebase periods.
   function automatic tpm_stretch_e stretch_step(
      input tpm_stretch_e cur,
      input logic trig,
      input logic tb_rise
   );
      tpm_stretch_e nxt;
      nxt = cur;
      if (trig) begin
         nxt = STR_WAIT1;
      end else begin
         case (cur)
            STR_IDLE: nxt = STR_IDLE;
            STR_WAIT1: nxt = tb_rise ? STR_WAIT2 : STR_WAIT1;
            STR_WAIT2: nxt = tb_rise ? STR_IDLE : STR_WAIT2;
            default: nxt = STR_IDLE;
         endcase
      end
      return nxt;
   endfunction

   // Chooses the raw trigger or the stretched one.
   function automatic logic pick_trigger(
      input logic stretch_on,
      input logic raw,
      input tpm_stretch_e nxt
   );
      return stretch_on ? (nxt != STR_IDLE) : raw;
   endfunction

   // Applies a programmable polarity. The strobes leave reset inverted,
   // so an idle low source shows as a high, inactive pin.
   function automatic logic apply_polarity(
      input logic act_high,
      input logic level
   );
      return act_high ? level : ~level;
   endfunction

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   // Writes update the direction and control registers; reads answer
   // one cycle later, unmapped addresses read as zero.
   // Strobes may follow back to back and the bus never waits.
   always_comb begin
      dir_next = dir_reg;
      ctl_next = ctl_reg;
      rdata_next = '0;
      if (I_WR) begin
         case (I_ADDR)
            // RL18 direction bit write
            REG_DIRECTION: dir_next = I_WDATA[PIN_COUNT-1:0];
            REG_CONTROL: ctl_next = tpm_control_s'(I_WDATA[CTL_WIDTH-1:0]);
            default: dir_next = dir_reg;
         endcase
      end
      if (I_RD) begin
         case (I_ADDR)
            REG_DIRECTION: rdata_next = {6'h00, dir_reg};
            REG_CONTROL: rdata_next = {7'h00, ctl_reg};
            REG_PIN_STATUS: rdata_next = {6'h00, sync2_reg};
            default: rdata_next = '0;
         endcase
      end
   end

   // RL19 all pins input at reset
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         dir_reg <= DIRECTION_RESET;
         ctl_reg <= tpm_control_s'(CONTROL_RESET);
         rdata_reg <= '0;
      end else begin
         dir_reg <= dir_next;
         ctl_reg <= ctl_next;
         rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------------------------------
   // Pin input path
   // ----------------------------------------------------------------
   // Pin levels are asynchronous to I_CLK, so two flip-flops come
   // first; the selectors only ever see the second stage.
   always_comb begin
      sel_next = sync2_reg; // RL1 input level to selectors
      // RL20 analog trigger takes slot 0
      if (ctl_reg.analog_trigger_enable) begin
         sel_next[PIN_AI_FIRST] = I_TIMING.analog_trigger;
      end
   end

   // Synchroniser and selector registers. Only the second stage feeds
   // logic, because the first may still be settling.
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sel_reg <= '0;
      end else begin
         sync1_reg <= I_TIMING_PIN_IN;
         sync2_reg <= sync1_reg;
         sel_reg <= sel_next;
      end
   end

   // ----------------------------------------------------------------
   // Trigger stretchers and conversion strobe shaping
   // ----------------------------------------------------------------
   assign ai_tb_rise = I_TIMING.ai_output_timebase & ~ai_tb_prev_reg;
   assign ao_tb_rise = I_TIMING.ao_output_timebase & ~ao_tb_prev_reg;

   // RL6 pulsewidth and polarity shaping
   // One-cycle mode keeps only the first clock of a raw high level.
   always_comb begin
      conv_shaped = ctl_reg.conv_one_cycle ?
         (I_TIMING.conversion_clock_raw & ~conv_prev_reg) :
         I_TIMING.conversion_clock_raw;
      // RL17 active low unless set high
      conv_next = apply_polarity(ctl_reg.conv_act_high, conv_shaped);
   end

   // Stretchers run whether or not stretching is on, which keeps them
   // simple; the output simply ignores them while it is off.
   always_comb begin
      // RL3 stretch first AI trigger
      str0_next = stretch_step(str0_reg,
         I_TIMING.ai_first_trigger_edge, ai_tb_rise);
      // RL5 stretch second AI trigger
      str1_next = stretch_step(str1_reg,
         I_TIMING.ai_second_trigger_edge, ai_tb_rise);
      // RL11 stretch first AO trigger
      str6_next = stretch_step(str6_reg,
         I_TIMING.ao_first_trigger_edge, ao_tb_rise);
      // RL12 stretch AI start trigger
      str7_next = stretch_step(str7_reg,
         I_TIMING.ai_start_trigger, ai_tb_rise);
   end

   // Edge history and stretcher state. The history flops reset low,
   // which matches the idle level of the timebases, so no false rise
   // follows reset.
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         ai_tb_prev_reg <= 1'b0;
         ao_tb_prev_reg <= 1'b0;
         conv_prev_reg <= 1'b0;
         conv_reg <= 1'b1;
         str0_reg <= STR_IDLE;
         str1_reg <= STR_IDLE;
         str6_reg <= STR_IDLE;
         str7_reg <= STR_IDLE;
      end else begin
         ai_tb_prev_reg <= I_TIMING.ai_output_timebase;
         ao_tb_prev_reg <= I_TIMING.ao_output_timebase;
         conv_prev_reg <= I_TIMING.conversion_clock_raw;
         conv_reg <= conv_next;
         str0_reg <= str0_next;
         str1_reg <= str1_next;
         str6_reg <= str6_next;
         str7_reg <= str7_next;
      end
   end

   // ----------------------------------------------------------------
   // Pin output selection
   // ----------------------------------------------------------------
   // Each output value is computed whether or not its driver is on, so
   // turning a pin around shows a settled level at once.
   always_comb begin
      out_next = '0;
      // RL2 raw or stretched pin 0
      out_next[PIN_AI_FIRST] = pick_trigger(
         ctl_reg.ai_trigger_stretch_enable,
         I_TIMING.ai_first_trigger_raw, str0_next);
      // RL4 raw or stretched pin 1
      out_next[PIN_AI_SECOND] = pick_trigger(
         ctl_reg.ai_trigger_stretch_enable,
         I_TIMING.ai_second_trigger_raw, str1_next);
      // RL6 shaped strobe on pin 2
      out_next[PIN_CONVERT] = conv_next;
      // RL7 counter 1 source
      out_next[PIN_G1_SOURCE] = I_TIMING.g1_source;
      // RL8 counter 1 gate
      out_next[PIN_G1_GATE] = I_TIMING.g1_gate;
      // RL9 update strobe, RL17 active low by default
      out_next[PIN_UPDATE] = apply_polarity(ctl_reg.upd_act_high,
         I_TIMING.ao_update_strobe);
      // RL10 raw or stretched pin 6
      out_next[PIN_AO_FIRST] = pick_trigger(
         ctl_reg.ao_trigger_stretch_enable,
         I_TIMING.ao_first_trigger_raw, str6_next);
      // RL12 AI start on pin 7
      out_next[PIN_AI_START] = pick_trigger(
         ctl_reg.ai_trigger_stretch_enable,
         I_TIMING.ai_start_trigger, str7_next);
      // The scan flag choice overrides the start trigger on pin 7.
      if (ctl_reg.pin7_source_select) begin
         // RL13 scan active flag polarity
         case (ctl_reg.scan_active_drive_mode)
            // RL14 high impedance mode drives low
            SCAN_HIGH_Z: out_next[PIN_AI_START] = 1'b0;
            SCAN_ACT_HIGH: out_next[PIN_AI_START] =
               I_TIMING.scan_active_flag;
            default: out_next[PIN_AI_START] = ~I_TIMING.scan_active_flag;
         endcase
      end
      // RL15 counter 0 source
      out_next[PIN_G0_SOURCE] = I_TIMING.g0_source;
      // RL16 counter 0 gate
      out_next[PIN_G0_GATE] = I_TIMING.g0_gate;
   end

   // Outputs are registered, so each pin lags its source by one clock.
   // That costs a cycle of latency but keeps the pads free of glitches.
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         out_reg <= '0;
      end else begin
         out_reg <= out_next;
      end
   end

   // ----------------------------------------------------------------
   // Output ports
   // ----------------------------------------------------------------
   // The enable comes straight from the direction register. Nothing
   // here can sense a clash on the pin, so outside drivers must have
   // let go before software sets a direction bit.
   // RL18 enable follows direction bit
   assign O_TIMING_PIN_OE = dir_reg;
   assign O_TIMING_PIN_OUT = out_reg;
   assign O_SELECTOR_IN = sel_reg;
   assign O_SHAPED_CONVERSION_STROBE = conv_reg;
   assign O_RDATA = rdata_reg;

endmodule

`default_nettype wire

// ==== verification/tpm_pin_mux_monitor.sv ====
// Checker for pin direction, output selection and selector timing.
`timescale 1ns/100ps
`default_nettype none
module tpm_pin_mux_monitor (
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic [tpm_pkg::ADDR_W-1:0] I_ADDR,
   input wire logic [tpm_pkg::DATA_W-1:0] I_WDATA,
   input wire logic I_WR,
   input wire tpm_pkg::tpm_timing_s I_TIMING,
   input wire logic [tpm_pkg::PIN_COUNT-1:0] I_TIMING_PIN_IN,
   input wire logic [tpm_pkg::PIN_COUNT-1:0] O_TIMING_PIN_OUT,
   input wire logic [tpm_pkg::PIN_COUNT-1:0] O_TIMING_PIN_OE,
   input wire logic [tpm_pkg::PIN_COUNT-1:0] O_SELECTOR_IN,
   input wire logic O_SHAPED_CONVERSION_STROBE
);
   import tpm_pkg::*;
   tpm_control_s ctl_reg, ctl_next;
   logic [1:0] age_reg, age_next;
   logic [PIN_COUNT-1:0] raw_exp;
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RST);
   // ----
   // Shadow state
   // ----
   // Age saturates at 3 so deep history is trusted only after reset.
   always_comb begin
      ctl_next = ctl_reg;
      age_next = age_reg;
      if (I_WR && I_ADDR == REG_CONTROL) begin
         ctl_next = I_WDATA[CTL_WIDTH-1:0];
      end
      if (age_reg != 2'h3) begin
         age_next = age_reg + 2'h1;
      end
   end
   always_ff @(posedge I_CLK or posedge I_RST) begin
      if (I_RST) begin
         ctl_reg <= CONTROL_RESET;
         age_reg <= 2'h0;
      end else begin
         ctl_reg <= ctl_next;
         age_reg <= age_next;
      end
   end
   // Unstretched pin values that the outputs show one edge later.
   always_comb begin
      raw_exp = {I_TIMING.g0_gate, I_TIMING.g0_source, 1'h0,
         I_TIMING.ao_first_trigger_raw,
         I_TIMING.ao_update_strobe ^ ~ctl_reg.upd_act_high,
         I_TIMING.g1_gate, I_TIMING.g1_source,
         I_TIMING.conversion_clock_raw ^ ~ctl_reg.conv_act_high,
         I_TIMING.ai_second_trigger_raw, I_TIMING.ai_first_trigger_raw};
      if (!ctl_reg.pin7_source_select) begin
         raw_exp[7] = I_TIMING.ai_start_trigger;
      end else if (ctl_reg.scan_active_drive_mode != SCAN_HIGH_Z) begin
         raw_exp[7] = I_TIMING.scan_active_flag ^
            ctl_reg.scan_active_drive_mode[1];
      end
   end
   // ----
   // Properties
   // ----
   sequence s_ai_trig;
      ctl_reg.ai_trigger_stretch_enable && I_TIMING.ai_first_trigger_edge;
   endsequence
   sequence s_ao_trig;
      ctl_reg.ao_trigger_stretch_enable && I_TIMING.ao_first_trigger_edge;
   endsequence
   a_reset_inputs: assert property ($past(I_RST) |-> O_TIMING_PIN_OE == '0)
      else $error("Pins left reset with a driver on.");
   a_dir_write: assert property (I_WR && I_ADDR == REG_DIRECTION |=>
      O_TIMING_PIN_OE == $past(I_WDATA[PIN_COUNT-1:0]))
      else $error("Direction write not applied.");
   a_dir_hold: assert property (!(I_WR && I_ADDR == REG_DIRECTION) |=>
      $stable(O_TIMING_PIN_OE))
      else $error("Direction changed without a write.");
   a_fixed_pins: assert property (1'h1 |=>
      (O_TIMING_PIN_OUT & 10'h338) == ($past(raw_exp) & 10'h338))
      else $error("Counter or update pin wrong.");
   a_conv_shape: assert property (!ctl_reg.conv_one_cycle |=>
      O_TIMING_PIN_OUT[2] == $past(raw_exp[2]) &&
      O_SHAPED_CONVERSION_STROBE == $past(raw_exp[2]))
      else $error("Conversion strobe wrong.");
   a_ai_raw: assert property (!ctl_reg.ai_trigger_stretch_enable |=>
      (O_TIMING_PIN_OUT & 10'h003) == ($past(raw_exp) & 10'h003))
      else $error("Raw analog input trigger wrong.");
   a_ao_raw: assert property (!ctl_reg.ao_trigger_stretch_enable |=>
      O_TIMING_PIN_OUT[6] == $past(raw_exp[6]))
      else $error("Raw analog output trigger wrong.");
   a_pin7_source: assert property (ctl_reg.pin7_source_select ||
      !ctl_reg.ai_trigger_stretch_enable |=>
      O_TIMING_PIN_OUT[7] == $past(raw_exp[7]))
      else $error("Pin 7 source wrong.");
   a_ai_stretch: assert property (s_ai_trig |=> O_TIMING_PIN_OUT[0])
      else $error("Pin 0 stretched pulse missing.");
   a_ao_stretch: assert property (s_ao_trig |=> O_TIMING_PIN_OUT[6])
      else $error("Pin 6 stretched pulse missing.");
   a_sel_follow: assert property (age_reg == 2'h3 |->
      (O_SELECTOR_IN & 10'h3FE) == ($past(I_TIMING_PIN_IN, 3) & 10'h3FE))
      else $error("Selector input does not follow pin.");
endmodule
`default_nettype wire

// ==== verification/tpm_ext_model.sv ====
// Model of the outside circuitry wired to the ten timing pins.
`timescale 1ns/100ps
`default_nettype none
module tpm_ext_model (
   input wire logic [9:0] i_oe,
   input wire logic [9:0] i_dut_out,
   input wire logic [9:0] i_drive,
   input wire logic [9:0] i_value,
   output logic [9:0] o_level
);
   // clash shows unknown
   // Two drivers give an unknown level so a clash cannot hide.
   always_comb begin
      for (int i = 0; i < 10; i++) begin
         if (i_oe[i] && i_drive[i]) begin
            o_level[i] = 'x;
         end else if (i_oe[i]) begin
            o_level[i] = i_dut_out[i];
         end else begin
            o_level[i] = i_drive[i] ? i_value[i] : 1'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== verification/tpm_pin_mux_test.sv ====
// Self-checking bench for the timing pin direction mux.
`timescale 1ns/100ps
`default_nettype none
module tpm_pin_mux_test;
   import tpm_pkg::*;
   logic clk, rst, wr, rd, strobe;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, ctl, d;
   tpm_timing_s tim, cur, r;
   logic [9:0] lvl, pout, poe, sel, drv, val, e;
   int n_fail, comparisons;
   tpm_pin_mux dut (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
      .I_TIMING(tim), .I_TIMING_PIN_IN(lvl), .O_TIMING_PIN_OUT(pout),
      .O_TIMING_PIN_OE(poe), .O_SELECTOR_IN(sel),
      .O_SHAPED_CONVERSION_STROBE(strobe));
   tpm_ext_model ext (.i_oe(poe), .i_dut_out(pout), .i_drive(drv),
      .i_value(val), .o_level(lvl));
   // ----
   // Helpers
   // ----
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task tally_and_finish();
      if (n_fail == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task wr_reg(input logic [ADDR_W-1:0] a, input logic [15:0] v);
      @(posedge clk);
      wr <= 1'h1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] v);
      @(posedge clk);
      rd <= 1'h1;
      addr <= a;
      @(posedge clk);
      rd <= 1'h0;
      @(negedge clk);
      chk(rdata, v);
   endtask
   // Expected pins with stretching off and the raw conversion width.
   function automatic logic [9:0] exp_pins(tpm_timing_s t, logic [15:0] c);
      logic [9:0] x;
      x = {t.g0_gate, t.g0_source, t.ai_start_trigger,
         t.ao_first_trigger_raw, t.ao_update_strobe ^ ~c[8], t.g1_gate,
         t.g1_source, t.conversion_clock_raw ^ ~c[7],
         t.ai_second_trigger_raw, t.ai_first_trigger_raw};
      if (c[2]) begin
         x[7] = (c[5:4] == SCAN_HIGH_Z) ? 1'h0 : t.scan_active_flag ^ c[5];
      end
      return x;
   endfunction
   // ----
   // Clock, watchdog and tests
   // ----
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   // The tests need well under a thousand cycles.
   initial begin
      repeat (4000) @(posedge clk);
      n_fail++;
      tally_and_finish();
   end
   initial begin
      {rst, wr, rd, addr, wdata, tim, drv, val} = '0;
      rst = 1'h1;
      n_fail = 0;
      comparisons = 0;
      r = tpm_timing_s'($urandom(86529));
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      @(negedge clk);
      chk(poe, 16'h0000);
      rd_chk(REG_DIRECTION, 16'h0000);
      rd_chk(REG_CONTROL, 16'h0000);
      // Outside drivers on a random subset; released pins rest high.
      @(posedge clk);
      drv <= 10'($urandom);
      val <= 10'($urandom);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk(sel, 10'((drv & val) | ~drv));
      rd_chk(REG_PIN_STATUS, {6'h00, (drv & val) | ~drv});
      @(posedge clk);
      drv[0] <= 1'h1;
      val[0] <= 1'h0;
      tim.analog_trigger <= 1'h1;
      wr_reg(REG_CONTROL, 16'h0008);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk(sel[0], 1'h1);
      wr_reg(REG_CONTROL, 16'h0000);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk(sel[0], 1'h0);
      @(posedge clk);
      drv <= '0;
      d = {6'h00, 10'($urandom)};
      wr_reg(REG_DIRECTION, d);
      @(negedge clk);
      chk(poe, d);
      wr_reg(4'hF, 16'hFFFF);
      rd_chk(4'hF, 16'h0000);
      rd_chk(REG_DIRECTION, d);
      wr_reg(REG_DIRECTION, 16'h03FF);
      // Every pin 7 source and scan mode, random polarities and signals.
      for (int k = 0; k < 8; k++) begin
         ctl = 16'($urandom) & 16'h01B8;
         ctl[2] = k[0];
         ctl[5:4] = k[2:1];
         wr_reg(REG_CONTROL, ctl);
         cur = tim;
         repeat (24) begin
            r = tpm_timing_s'($urandom);
            @(posedge clk);
            tim <= r;
            @(negedge clk);
            e = exp_pins(cur, ctl);
            chk(pout, e);
            chk(strobe, e[2]);
            cur = r;
         end
      end
      // One trigger pulse, then two timebase rises end the stretch.
      @(posedge clk);
      tim <= '0;
      wr_reg(REG_CONTROL, 16'h0003);
      @(posedge clk);
      tim.ai_first_trigger_edge <= 1'h1;
      tim.ai_second_trigger_edge <= 1'h1;
      tim.ao_first_trigger_edge <= 1'h1;
      tim.ai_start_trigger <= 1'h1;
      @(posedge clk);
      tim <= '0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(pout & 10'h0C3, 10'h0C3);
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         tim.ai_output_timebase <= 1'h1;
         tim.ao_output_timebase <= 1'h1;
         @(posedge clk);
         tim <= '0;
         @(negedge clk);
         chk(pout & 10'h0C3, k ? 10'h000 : 10'h0C3);
      end
      // One-cycle conversion strobe, active low: a long raw level gives
      // a single low cycle on the pin and on the strobe output.
      wr_reg(REG_CONTROL, 16'h0040);
      @(posedge clk);
      tim.conversion_clock_raw <= 1'h1;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         @(negedge clk);
         chk({pout[2], strobe}, k ? 2'h3 : 2'h0);
      end
      @(posedge clk);
      rst <= 1'h1;
      @(posedge clk);
      rst <= 1'h0;
      @(negedge clk);
      chk(poe, 16'h0000);
      tally_and_finish();
   end
endmodule
bind tpm_pin_mux tpm_pin_mux_monitor mon (.I_CLK(I_CLK), .I_RST(I_RST),
   .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_TIMING(I_TIMING),
   .I_TIMING_PIN_IN(I_TIMING_PIN_IN), .O_TIMING_PIN_OUT(O_TIMING_PIN_OUT),
   .O_TIMING_PIN_OE(O_TIMING_PIN_OE), .O_SELECTOR_IN(O_SELECTOR_IN),
   .O_SHAPED_CONVERSION_STROBE(O_SHAPED_CONVERSION_STROBE));
`default_nettype wire
